// ==== common/epsc_pkg.sv ====
// Package for the execution-pipeline stall control block.
// Assumes one core clock and a register bus following APB.
package epsc_pkg;

   // -----------------------------------------------------------------
   // Widths and counts
   // -----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int REG_N = 16;
   localparam int REG_W = 4;
   localparam int SHIFT_W = 6;
   localparam int APB_AW = 8;
   localparam int PSL_GAP_CYCLES = 2;

   // -----------------------------------------------------------------
   // Register map, byte addresses
   // -----------------------------------------------------------------
   localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFF_STAT = 8'h04;
   localparam logic [APB_AW-1:0] OFF_SHIFT = 8'h08;
   localparam logic [APB_AW-1:0] OFF_ADDR = 8'h0C;
   localparam logic [APB_AW-1:0] OFF_STATUS_LW = 8'h10;
   localparam logic [APB_AW-1:0] OFF_Q = 8'h14;

   // Control register fields.
   localparam int CTRL_FORCE_SRC = 0;
   localparam int CTRL_FORCE_DST = 1;
   localparam int CTRL_FORCE_BQ = 2;
   localparam int CTRL_W = 3;

   // Status register fields; the two sticky ones are write-one-to-clear.
   localparam int STAT_S3_STALL = 0;
   localparam int STAT_S4_STALL = 1;
   localparam int STAT_LATCH_BUSY = 2;
   localparam int STAT_PSL_HAZARD = 3;
   localparam int STAT_READ_DST_ERR = 4;

   // Status longword bits used by the sequencer and reset values.
   localparam int FPD_BIT = 27;
   localparam int TP_BIT = 30;
   localparam logic [DATA_W-1:0] STATUS_LW_RST = 32'h0000_0000;
   localparam logic [SHIFT_W-1:0] SHIFT_RST = 6'h00;

   // -----------------------------------------------------------------
   // Microword encodings
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_NONE = 2'h0, SRC_REG = 2'h1, SRC_QUEUE = 2'h2, SRC_STATUS = 2'h3
   } epsc_src_e;

   typedef enum logic [2:0] {
      DST_NONE = 3'h0, DST_REG = 3'h1, DST_QUEUE = 3'h2, DST_SHIFT = 3'h3,
      DST_STATUS = 3'h4
   } epsc_dst_e;

   typedef enum logic [1:0] {
      ALU_PASS_A = 2'h0, ALU_ADD = 2'h1, ALU_SUB = 2'h2, ALU_AND = 2'h3
   } epsc_alu_e;

   typedef enum logic [1:0] {
      MRQ_NONE = 2'h0, MRQ_READ = 2'h1, MRQ_WRITE = 2'h2
   } epsc_mrq_e;

   typedef struct packed {
      logic valid;
      logic last_cycle;
      epsc_src_e a_sel;
      logic [REG_W-1:0] a_reg;
      epsc_src_e b_sel;
      logic [REG_W-1:0] b_reg;
      epsc_alu_e alu_op;
      logic wbus_shift;
      logic addr_load;
      logic q_load;
      epsc_dst_e dst;
      logic [REG_W-1:0] dst_reg;
      epsc_mrq_e memory_request_field;
      logic bq_sync;
   } epsc_uword_s;

   typedef struct packed {
      logic valid;
      logic literal;
      logic [DATA_W-1:0] data;
   } epsc_srcq_s;

   typedef struct packed {
      logic valid;
      logic memory;
      logic [REG_W-1:0] rnum;
   } epsc_dstq_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [REG_W-1:0] rnum;
      logic [DATA_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } epsc_memreq_s;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } epsc_cc_s;

endpackage : epsc_pkg

// ==== rtl/epsc_top.sv ====
// Three-stage microword pipeline with its stall, bypass and no-op logic.
// Assumes the sequencer, decode queues and memory unit share pclk.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Three stages: fetch, execute, writeback.
// - Writeback never stalls, always completes.
// - Bypass results of two preceding microwords.
// - Address register loads from ALU, bypassed.
// - Memory write from write bus; read into register.
// - Q register loads from shifter output.
// - Status longword from write bus, usable source.
// - Status bits need two cycles before dispatch.
// - Branch data: B bus next, codes second.
// - Fetch stalls on invalid source operand.
// - Valid bit cleared during pending memory read.
// - Execute stalls on missing destination entry.
// - Execute stalls on missing physical address.
// - Execute stalls while request latch busy.
// - Execute stalls on missing branch entry.
// - Execute stalls when float must retire first.
// - Any destination requests the result mux.
// - Fetch stall inserts no-op into execute.
// - Execute stall holds fetch, no-op writeback.
// - Fetch stall also stalls the sequencer.
// - Filler microword never stalls, signals last.
// - Field-queue loop advances unless execute stalls.
module epsc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [epsc_pkg::APB_AW-1:0] paddr,
   input wire logic [epsc_pkg::DATA_W-1:0] pwdata,
   output logic [epsc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire epsc_pkg::epsc_uword_s uw_in,
   output logic seq_stall,
   input wire epsc_pkg::epsc_srcq_s srcq,
   output logic srcq_pop,
   input wire epsc_pkg::epsc_dstq_s dstq,
   output logic dstq_pop,
   input wire logic pa_valid,
   output logic pa_pop,
   input wire logic bq_valid,
   output logic bq_pop,
   input wire logic rq_fbox_first,
   output epsc_pkg::epsc_memreq_s mem_req,
   input wire logic mem_ack,
   input wire logic rd_done,
   input wire logic [epsc_pkg::REG_W-1:0] rd_reg,
   input wire logic [epsc_pkg::DATA_W-1:0] rd_data,
   output logic store_valid,
   output logic [epsc_pkg::DATA_W-1:0] store_data,
   output logic [epsc_pkg::DATA_W-1:0] b_source_bus,
   output epsc_pkg::epsc_cc_s alu_cc,
   output logic first_part_done_bit,
   output logic trace_pending_bit
);
   import epsc_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   epsc_uword_s s3_reg, s4_reg;
   logic [DATA_W-1:0] a_stage_reg, b_stage_reg;
   logic s5_valid_reg;
   epsc_dst_e s5_kind_reg;
   logic [REG_W-1:0] s5_rnum_reg;
   logic [DATA_W-1:0] write_bus_reg;
   epsc_cc_s cc_reg;
   logic [DATA_W-1:0] rf_mem [REG_N];
   logic [REG_N-1:0] rf_valid_reg;
   logic [SHIFT_W-1:0] shift_count_reg;
   logic [DATA_W-1:0] address_reg, q_reg, status_longword;
   epsc_memreq_s memory_request_latch;
   logic store_valid_reg;
   logic [DATA_W-1:0] store_data_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic hazard_reg, rd_err_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic pready_reg, pslverr_reg;

   logic hold_s3, hold_s4, s3_wait, s4_wait;
   logic [DATA_W-1:0] opnd [2];
   epsc_src_e src_sel [2];
   logic [REG_W-1:0] src_num [2];
   logic [DATA_W-1:0] alu_out, shift_out, write_bus;
   logic [2*DATA_W-1:0] shift_quad;
   logic alu_carry;
   logic dstq_ref, s4_wr_reg;
   logic [REG_W-1:0] s4_wr_num;
   logic s4_adv, s3_uses_q;
   logic apb_wr;

   // -----------------------------------------------------------------
   // Operand fetch: sources, bypass and fetch-stage wait
   // -----------------------------------------------------------------
   assign src_sel[0] = s3_reg.a_sel;
   assign src_sel[1] = s3_reg.b_sel;
   assign src_num[0] = s3_reg.a_reg;
   assign src_num[1] = s3_reg.b_reg;

   always_comb begin
      logic is_reg;
      logic [REG_W-1:0] num;
      is_reg = 1'b0;
      num = '0;
      s3_wait = 1'b0;
      s3_uses_q = 1'b0;
      for (int i = 0; i < 2; i++) begin
         is_reg = 1'b0;
         num = src_num[i];
         opnd[i] = '0;
         unique case (src_sel[i])
            SRC_NONE: opnd[i] = '0;
            SRC_REG: is_reg = 1'b1;
            SRC_QUEUE: begin
               s3_uses_q = 1'b1;
               if (!srcq.valid || ctrl_reg[CTRL_FORCE_SRC]) begin
                  s3_wait = 1'b1;
               end
               if (srcq.literal) begin
                  opnd[i] = srcq.data;
               end else begin
                  is_reg = 1'b1;
                  num = srcq.data[REG_W-1:0];
               end
            end
            SRC_STATUS: opnd[i] = status_longword;
         endcase
         if (is_reg) begin
            // Newest producer wins: the execute stage, then writeback.
            if (s4_reg.valid && s4_wr_reg && s4_wr_num == num) begin
               opnd[i] = write_bus;
            end else if (s5_valid_reg && s5_kind_reg == DST_REG && s5_rnum_reg == num) begin
               opnd[i] = write_bus_reg;
            end else begin
               opnd[i] = rf_mem[num];
            end
            // A read issued by the execute-stage microword has not yet
            // cleared the valid bit, so it is checked here as well.
            if (!rf_valid_reg[num] ||
                (s4_reg.valid && s4_reg.memory_request_field == MRQ_READ && s4_reg.dst_reg == num)) begin
               s3_wait = 1'b1;
            end
         end
      end
      // A filler microword has no valid operation, so it never waits.
      s3_wait = s3_wait & s3_reg.valid;
   end

   // -----------------------------------------------------------------
   // Execute stage: ALU, shifter and execute-stage wait
   // -----------------------------------------------------------------
   always_comb begin
      alu_carry = 1'b0;
      alu_out = '0;
      unique case (s4_reg.alu_op)
         ALU_PASS_A: alu_out = a_stage_reg;
         ALU_ADD: {alu_carry, alu_out} = {1'b0, a_stage_reg} + {1'b0, b_stage_reg};
         ALU_SUB: {alu_carry, alu_out} = {1'b0, a_stage_reg} - {1'b0, b_stage_reg};
         ALU_AND: alu_out = a_stage_reg & b_stage_reg;
      endcase
   end

   assign shift_quad = {a_stage_reg, b_stage_reg} >> shift_count_reg;
   assign shift_out = shift_quad[DATA_W-1:0];
   assign write_bus = s4_reg.wbus_shift ? shift_out : alu_out;

   assign dstq_ref = s4_reg.dst == DST_QUEUE;
   assign s4_wr_reg = (s4_reg.dst == DST_REG) || (dstq_ref && !dstq.memory);
   assign s4_wr_num = dstq_ref ? dstq.rnum : s4_reg.dst_reg;

   always_comb begin
      s4_wait = 1'b0;
      if (dstq_ref && (!dstq.valid || ctrl_reg[CTRL_FORCE_DST])) begin
         s4_wait = 1'b1;
      end
      if (dstq_ref && dstq.valid && dstq.memory && !pa_valid) begin
         s4_wait = 1'b1;
      end
      if (s4_reg.memory_request_field != MRQ_NONE && memory_request_latch.valid) begin
         s4_wait = 1'b1;
      end
      if (s4_reg.bq_sync && (!bq_valid || ctrl_reg[CTRL_FORCE_BQ])) begin
         s4_wait = 1'b1;
      end
      if (rq_fbox_first && s4_reg.dst != DST_NONE) begin
         s4_wait = 1'b1;
      end
      s4_wait = s4_wait & s4_reg.valid;
   end

   // -----------------------------------------------------------------
   // Hold signals and queue pops
   // -----------------------------------------------------------------
   assign hold_s4 = s4_wait;
   assign hold_s3 = s3_wait | hold_s4;
   assign s4_adv = s4_reg.valid & ~hold_s4;
   assign seq_stall = hold_s3;
   assign srcq_pop = s3_reg.valid & s3_uses_q & ~hold_s3;
   assign dstq_pop = s4_adv & dstq_ref;
   assign pa_pop = s4_adv & dstq_ref & dstq.memory;
   assign bq_pop = s4_adv & s4_reg.bq_sync;

   // -----------------------------------------------------------------
   // Pipeline latches
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s3_reg <= '0;
      end else if (!hold_s3) begin
         s3_reg <= uw_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s4_reg <= '0;
         a_stage_reg <= '0;
         b_stage_reg <= '0;
      end else if (!hold_s4) begin
         if (hold_s3) begin
            s4_reg <= '0;
         end else begin
            s4_reg <= s3_reg;
            a_stage_reg <= opnd[0];
            b_stage_reg <= opnd[1];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s5_valid_reg <= 1'b0;
         s5_kind_reg <= DST_NONE;
         s5_rnum_reg <= '0;
         write_bus_reg <= '0;
         cc_reg <= '0;
         store_valid_reg <= 1'b0;
         store_data_reg <= '0;
      end else begin
         s5_valid_reg <= s4_adv;
         store_valid_reg <= pa_pop;
         if (s4_adv) begin
            s5_kind_reg <= s4_wr_reg ? DST_REG : (dstq_ref ? DST_NONE : s4_reg.dst);
            s5_rnum_reg <= s4_wr_num;
            write_bus_reg <= write_bus;
            store_data_reg <= write_bus;
            cc_reg.n <= alu_out[DATA_W-1];
            cc_reg.z <= alu_out == '0;
            cc_reg.c <= alu_carry;
            cc_reg.v <= (s4_reg.alu_op == ALU_ADD) ?
               (a_stage_reg[DATA_W-1] == b_stage_reg[DATA_W-1]) &&
               (alu_out[DATA_W-1] != a_stage_reg[DATA_W-1]) :
               (s4_reg.alu_op == ALU_SUB) &&
               (a_stage_reg[DATA_W-1] != b_stage_reg[DATA_W-1]) &&
               (alu_out[DATA_W-1] != a_stage_reg[DATA_W-1]);
         end
      end
   end

   // -----------------------------------------------------------------
   // Special registers
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_reg <= '0;
         q_reg <= '0;
      end else if (s4_adv) begin
         if (s4_reg.addr_load) begin
            address_reg <= alu_out;
         end
         if (s4_reg.q_load) begin
            q_reg <= shift_out;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_longword <= STATUS_LW_RST;
         shift_count_reg <= SHIFT_RST;
      end else begin
         if (apb_wr && paddr == OFF_SHIFT) begin
            shift_count_reg <= pwdata[SHIFT_W-1:0];
         end
         // Writeback is unconditional; it overrides a software write.
         if (s5_valid_reg && s5_kind_reg == DST_SHIFT) begin
            shift_count_reg <= write_bus_reg[SHIFT_W-1:0];
         end
         if (s5_valid_reg && s5_kind_reg == DST_STATUS) begin
            status_longword <= write_bus_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // Register file and valid bits
   // -----------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (rd_done) begin
         rf_mem[rd_reg] <= rd_data;
      end
      if (s5_valid_reg && s5_kind_reg == DST_REG) begin
         rf_mem[s5_rnum_reg] <= write_bus_reg;
      end
   end

   // A read starting in the same cycle wins over a completion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_valid_reg <= '1;
      end else begin
         if (s5_valid_reg && s5_kind_reg == DST_REG) begin
            rf_valid_reg[s5_rnum_reg] <= 1'b1;
         end
         if (rd_done) begin
            rf_valid_reg[rd_reg] <= 1'b1;
         end
         if (s4_adv && s4_reg.memory_request_field == MRQ_READ && s4_reg.dst == DST_REG) begin
            rf_valid_reg[s4_reg.dst_reg] <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Memory request latch
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_request_latch <= '0;
      end else if (s4_adv && s4_reg.memory_request_field == MRQ_WRITE) begin
         memory_request_latch.valid <= 1'b1;
         memory_request_latch.write <= 1'b1;
         memory_request_latch.rnum <= '0;
         memory_request_latch.addr <= s4_reg.addr_load ? alu_out : address_reg;
         memory_request_latch.data <= write_bus;
      end else if (s4_adv && s4_reg.memory_request_field == MRQ_READ && s4_reg.dst == DST_REG) begin
         memory_request_latch.valid <= 1'b1;
         memory_request_latch.write <= 1'b0;
         memory_request_latch.rnum <= s4_reg.dst_reg;
         memory_request_latch.addr <= s4_reg.addr_load ? alu_out : address_reg;
         memory_request_latch.data <= '0;
      end else if (mem_ack) begin
         memory_request_latch.valid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------------
   assign apb_wr = psel & penable & pready_reg & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
      end else if (apb_wr && paddr == OFF_CTRL) begin
         ctrl_reg <= pwdata[CTRL_W-1:0];
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hazard_reg <= 1'b0;
         rd_err_reg <= 1'b0;
      end else begin
         if (apb_wr && paddr == OFF_STAT) begin
            hazard_reg <= hazard_reg & ~pwdata[STAT_PSL_HAZARD];
            rd_err_reg <= rd_err_reg & ~pwdata[STAT_READ_DST_ERR];
         end
         if (s3_reg.valid && s3_reg.last_cycle &&
             ((s4_reg.valid && s4_reg.dst == DST_STATUS) ||
              (s5_valid_reg && s5_kind_reg == DST_STATUS))) begin
            hazard_reg <= 1'b1;
         end
         if (s4_adv && s4_reg.memory_request_field == MRQ_READ && s4_reg.dst != DST_REG) begin
            rd_err_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= psel & ~penable;
         pslverr_reg <= 1'b0;
         if (psel && !penable) begin
            prdata_reg <= '0;
            unique case (paddr)
               OFF_CTRL: prdata_reg[CTRL_W-1:0] <= ctrl_reg;
               OFF_STAT: begin
                  prdata_reg[STAT_S3_STALL] <= hold_s3;
                  prdata_reg[STAT_S4_STALL] <= hold_s4;
                  prdata_reg[STAT_LATCH_BUSY] <= memory_request_latch.valid;
                  prdata_reg[STAT_PSL_HAZARD] <= hazard_reg;
                  prdata_reg[STAT_READ_DST_ERR] <= rd_err_reg;
               end
               OFF_SHIFT: prdata_reg[SHIFT_W-1:0] <= shift_count_reg;
               OFF_ADDR: prdata_reg <= address_reg;
               OFF_STATUS_LW: prdata_reg <= status_longword;
               OFF_Q: prdata_reg <= q_reg;
               default: pslverr_reg <= 1'b1;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mem_req = memory_request_latch;
   assign store_valid = store_valid_reg;
   assign store_data = store_data_reg;
   assign b_source_bus = b_stage_reg;
   assign alu_cc = cc_reg;
   assign first_part_done_bit = status_longword[FPD_BIT];
   assign trace_pending_bit = status_longword[TP_BIT];

endmodule : epsc_top

`default_nettype wire

// ==== test/epsc_assertions.sv ====
// Port checker for the stall control block.
// Bound to epsc_top and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module epsc_chk
   import epsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire epsc_pkg::epsc_srcq_s srcq,
   input wire logic srcq_pop,
   input wire epsc_pkg::epsc_dstq_s dstq,
   input wire logic dstq_pop,
   input wire logic pa_valid,
   input wire logic pa_pop,
   input wire logic bq_valid,
   input wire logic bq_pop,
   input wire logic rq_fbox_first,
   input wire epsc_pkg::epsc_memreq_s mem_req,
   input wire logic mem_ack,
   input wire logic store_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_answer_a: assert property (psel && !penable |=> pready) else $error("late answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
   err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   src_pop_a: assert property (srcq_pop |-> srcq.valid)
      else $error("source pop");
   dst_pop_a: assert property (dstq_pop |-> dstq.valid && !rq_fbox_first)
      else $error("dest pop");
   pa_pop_a: assert property (pa_pop |-> pa_valid)
      else $error("pa pop");
   bq_pop_a: assert property (bq_pop |-> bq_valid)
      else $error("branch pop");
   latch_hold_a: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
      else $error("latch changed");
   latch_free_a: assert property (mem_req.valid && mem_ack |=> !mem_req.valid)
      else $error("latch kept");
   store_pa_a: assert property (store_valid |-> $past(pa_pop))
      else $error("store without pa");
endmodule : epsc_chk
bind epsc_top epsc_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .srcq,
   .srcq_pop, .dstq, .dstq_pop, .pa_valid, .pa_pop, .bq_valid, .bq_pop, .rq_fbox_first,
   .mem_req, .mem_ack, .store_valid);
`default_nettype wire

// ==== test/epsc_mem_model.sv ====
// Memory unit stand-in: takes the request latch, refills the PA queue.
// Assumes the latch of epsc_top on the same pclk.
`timescale 1ns/10ps
`default_nettype none
module epsc_mem_model
   import epsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire epsc_pkg::epsc_memreq_s mem_req,
   input wire logic pa_pop,
   output logic mem_ack,
   output logic pa_valid,
   output logic rd_done,
   output logic [epsc_pkg::REG_W-1:0] rd_reg,
   output logic [epsc_pkg::DATA_W-1:0] rd_data
);
   logic [1:0] cnt;
   logic [1:0] dly;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         cnt <= 2'h0;
         dly <= 2'h0;
         pa_valid <= 1'b0;
         rd_done <= 1'b0;
         rd_reg <= 4'h0;
         rd_data <= 32'h0;
      end else begin
         // Answers alternate between prompt and three cycles late.
         mem_ack <= mem_req.valid && !mem_ack && cnt == dly;
         cnt <= (mem_req.valid && !mem_ack) ? cnt + 2'h1 : 2'h0;
         dly <= mem_ack ? dly ^ 2'h3 : dly;
         rd_done <= mem_ack && !mem_req.write;
         rd_reg <= mem_req.rnum;
         rd_data <= mem_ack ? mem_req.addr : ~rd_data;
         pa_valid <= !pa_pop;
      end
   end
endmodule : epsc_mem_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for epsc_top with a memory unit model.
// Assumes epsc_pkg, the checker and the model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import epsc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_stall, dv, dmem;
   logic srcq_pop, dstq_pop, pa_valid, pa_pop, bq_valid, bq_pop, rq_fbox_first;
   logic mem_ack, rd_done, store_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, store_data, rd_data, v;
   logic [3:0] rd_reg;
   logic [31:0] sd [8];
   logic [63:0] exp_q [$];
   int hd, tl, errors, n_tests;
   integer seed;
   epsc_uword_s uw_in, lw;
   epsc_memreq_s mem_req;
   epsc_srcq_s srcq;
   epsc_dstq_s dstq;
   assign srcq = {hd < tl, 1'b1, sd[hd[2:0]]};
   assign dstq = {dv, dmem, 4'h3};
   epsc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .uw_in, .seq_stall, .srcq, .srcq_pop, .dstq, .dstq_pop, .pa_valid,
      .pa_pop, .bq_valid, .bq_pop, .rq_fbox_first, .mem_req, .mem_ack, .rd_done, .rd_reg,
      .rd_data, .store_valid, .store_data, .b_source_bus(), .alu_cc(),
      .first_part_done_bit(), .trace_pending_bit());
   epsc_mem_model i_mem (.pclk, .presetn, .mem_req, .pa_pop, .mem_ack, .pa_valid, .rd_done,
      .rd_reg, .rd_data);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (srcq_pop) hd <= hd + 1;
      if (dstq_pop) dv <= 1'b0;
      if (bq_pop) bq_valid <= 1'b0;
   end
   // -----------------------------------------------------------------
   // Result monitor
   // -----------------------------------------------------------------
   always @(negedge pclk) begin
      if (pready) check("apb", {31'h0, pslverr, prdata}, exp_q.pop_front());
      if (mem_req.valid && mem_ack) check("mem", {mem_req.addr, mem_req.data}, exp_q.pop_front());
      if (store_valid) check("store", {32'h0, store_data}, exp_q.pop_front());
   end
   task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic conclude();
      errors += exp_q.size();
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task automatic hang();
      errors++;
      conclude();
   endtask : hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [32:0] e);
      int n;
      exp_q.push_back({31'h0, e});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 20);
      if (n >= 20) hang();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic put(input logic [31:0] x);
      @(posedge pclk);
      sd[tl[2:0]] <= x;
      tl <= tl + 1;
   endtask : put
   task automatic send(input epsc_uword_s w);
      int n;
      uw_in <= w;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (seq_stall && n < 50);
      if (n >= 50) hang();
      @(posedge pclk);
   endtask : send
   function automatic epsc_uword_s mk(epsc_src_e a, epsc_dst_e d, logic [3:0] r,
         epsc_mrq_e m, logic b);
      mk = '{valid:1'b1, last_cycle:1'b0, a_sel:a, a_reg:r, b_sel:SRC_NONE, b_reg:4'h0,
         alu_op:ALU_PASS_A, wbus_shift:1'b0, addr_load:1'b1, q_load:1'b0, dst:d,
         dst_reg:r, memory_request_field:m, bq_sync:b};
   endfunction : mk
   initial begin
      seed = 32'hDA97;
      {psel, penable, pwrite, paddr, pwdata, dv, dmem, bq_valid, rq_fbox_first} = '0;
      uw_in = '0;
      {hd, tl, errors, n_tests} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_STATUS_LW, '0, {1'b0, STATUS_LW_RST});
      apb(1'b0, 8'h3C, '0, {1'b1, 32'h0});
      v = $random(seed);
      apb(1'b1, OFF_SHIFT, v, '0);
      apb(1'b0, OFF_SHIFT, '0, {27'h0, v[5:0]});
      send(mk(SRC_QUEUE, DST_STATUS, 4'h0, MRQ_NONE, 1'b0));
      uw_in <= '0;
      @(negedge pclk) check("fetch stall", {63'h0, seq_stall}, 64'h1);
      put(v);
      repeat (6) @(posedge pclk);
      apb(1'b0, OFF_ADDR, '0, {1'b0, v});
      v = $random(seed);
      put(v);
      send(mk(SRC_QUEUE, DST_REG, 4'h5, MRQ_NONE, 1'b0));
      send(mk(SRC_REG, DST_STATUS, 4'h5, MRQ_NONE, 1'b0));
      uw_in <= '0;
      repeat (6) @(posedge pclk);
      apb(1'b0, OFF_STATUS_LW, '0, {1'b0, v});
      repeat (2) begin
         v = $random(seed);
         put(v);
         exp_q.push_back({v, v});
      end
      send(mk(SRC_QUEUE, DST_NONE, 4'h0, MRQ_WRITE, 1'b0));
      send(mk(SRC_QUEUE, DST_NONE, 4'h0, MRQ_WRITE, 1'b0));
      uw_in <= '0;
      repeat (12) @(posedge pclk);
      put(v);
      lw = mk(SRC_NONE, DST_NONE, 4'h0, MRQ_NONE, 1'b0);
      lw.last_cycle = 1'b1;
      send(mk(SRC_QUEUE, DST_STATUS, 4'h0, MRQ_READ, 1'b0));
      send(lw);
      uw_in <= '0;
      repeat (6) @(posedge pclk);
      apb(1'b0, OFF_STAT, '0, {1'b0, 32'h18});
      apb(1'b1, OFF_STAT, 32'h18, {1'b0, 32'h18});
      apb(1'b0, OFF_STAT, '0, '0);
      v = $random(seed);
      put(v);
      bq_valid <= 1'b1;
      exp_q.push_back({32'h0, v});
      send(mk(SRC_QUEUE, DST_QUEUE, 4'h0, MRQ_NONE, 1'b1));
      uw_in <= '0;
      repeat (3) @(negedge pclk);
      check("dest wait", {63'h0, seq_stall}, 64'h1);
      @(posedge pclk) {dv, dmem, rq_fbox_first} <= 3'h7;
      @(negedge pclk) check("retire wait", {63'h0, seq_stall}, 64'h1);
      @(posedge pclk) {rq_fbox_first, bq_valid} <= 2'h0;
      @(negedge pclk) check("branch wait", {63'h0, seq_stall}, 64'h1);
      @(posedge pclk) bq_valid <= 1'b1;
      repeat (10) @(posedge pclk);
      conclude();
   end
endmodule : testbench
`default_nettype wire
